// ===== core/link_aggregation_group_control.sv
// aggregation group control: apb registers, egress pick, flap counters
// Functional notes
// R1 - a group takes at most eight members; a ninth is refused
// R2 - a member is active only when oper up, admin up and linked
// R3 - egress member picked by flow hash so one flow keeps order
// R4 - six hash field choices, three mac based and three ip based
// R5 - local preference sends known unicast only via local members if any
// R6 - local preference leaves unknown unicast, broadcast, multicast alone
// R7 - without local preference known unicast may use any member
// R8 - spanning tree mode treats the whole group as one participant
// R9 - group link state reads up, up over optical module, or down
// R10 - with link trap on, each link state change raises an event
// R11 - member flap count rises on admin shutdown or link loss
// R12 - group admin shutdown bumps group count, not member counts
// R13 - group count rises when the last active member goes inactive
// R14 - clear command zeroes all group and member flap counts
// R15 - an admin disabled group neither sends nor receives
// R16 - static group members neither send nor receive lacp frames
// R17 - flap counts saturate and reset to zero
// R18 - frames for a group with no active member are dropped
`timescale 1ns/10ps

module lag_frame_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             push, pop;

    // flags follow the fill count; ready is a flop so the port is registered
    assign outValid = count != '0;
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // pointers and count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b1;
        end else begin
            inReady <= pop || (count + {{AW{1'b0}}, push}) != (AW+1)'(DEPTH);
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : lag_frame_fifo

module link_aggregation_group_control #(
    parameter int MAX_MEMBERS = lag_pkg::MAX_MEMBERS,
    parameter int FIFO_DEPTH  = lag_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    // physical port status
    input  wire logic [lag_pkg::NUM_PORTS-1:0] portLink,
    input  wire logic [lag_pkg::NUM_PORTS-1:0] portOperUp,
    input  wire logic [lag_pkg::NUM_PORTS-1:0] portSfp,
    input  wire logic                          stpForward,
    // frames toward the group
    input  wire logic                          frameValid,
    output logic                               frameReady,
    input  wire lag_pkg::frame_desc_t          frameDesc,
    // egress decision
    output logic                               egressValid,
    input  wire logic                          egressReady,
    output lag_pkg::egress_t                   egressDesc,
    // per port and group controls
    output logic [lag_pkg::NUM_PORTS-1:0]      txEnable,
    output logic [lag_pkg::NUM_PORTS-1:0]      rxEnable,
    output logic [lag_pkg::NUM_PORTS-1:0]      lacpBlock,
    output logic                               stpGroup,
    output lag_pkg::link_state_t               linkState,
    output logic                               linkEvent
);
    localparam int NP = lag_pkg::NUM_PORTS;
    localparam int FW = lag_pkg::FLAP_W;
    localparam int DW = $bits(lag_pkg::frame_desc_t);
    localparam logic [FW-1:0] FLAP_MAX = {FW{1'b1}};

    // configuration and state
    logic                 adminEn;
    logic                 stpMode;
    logic                 linkTrap;
    logic                 localPref;
    logic                 staticMode;
    logic [2:0]           hashSel;
    logic [NP-1:0]        memberMask;
    logic [NP-1:0]        portAdmin;
    logic [NP-1:0]        localMask;
    logic [NP-1:0]        activeMask;
    logic [NP-1:0]        prevLink;
    logic                 rejected;
    logic [FW-1:0]        grpFlap;
    logic [FW-1:0]        portFlap [NP];

    // bus decode
    logic                 accessEnd;
    logic                 wrEn;
    logic                 wrCtrl;
    logic                 wrMembers;
    logic                 wrPortAdmin;
    logic                 clearCmd;
    logic                 overLimit;
    logic                 isPortFlap;
    logic [31:0]          next_prdata;
    logic                 next_pslverr;
    logic [NP-1:0]        next_active;
    lag_pkg::link_state_t next_link;

    // egress pick
    logic [DW-1:0]        qBits;
    lag_pkg::frame_desc_t qDesc;
    logic                 qValid;
    logic                 qReady;
    logic                 selFire;
    logic [127:0]         hashKey;
    logic [7:0]           hashVal;
    logic [NP-1:0]        localAct;
    logic [NP-1:0]        cand;
    logic [4:0]           candCnt;
    logic [7:0]           nth;
    logic [7:0]           seen;
    logic [3:0]           pick;
    logic                 selDrop;

    function automatic logic [4:0] popcnt(input logic [NP-1:0] v);
        logic [4:0] c;
        c = '0;
        for (int i = 0; i < NP; i++) begin
            c = c + {4'h0, v[i]};
        end
        return c;
    endfunction : popcnt

    function automatic logic [FW-1:0] bump(input logic [FW-1:0] v);
        return (v == FLAP_MAX) ? v : v + 1'b1;
    endfunction : bump

    // apb strobes; writes land at the access edge
    assign accessEnd   = psel && penable && pready;
    assign wrEn        = accessEnd && pwrite && !pslverr;
    assign wrCtrl      = wrEn && paddr == lag_pkg::OFS_CTRL;
    assign wrMembers   = wrEn && paddr == lag_pkg::OFS_MEMBERS;
    assign wrPortAdmin = wrEn && paddr == lag_pkg::OFS_PORT_ADMIN;
    assign clearCmd    = wrCtrl && pwdata[lag_pkg::CTRL_CLEAR];
    assign overLimit   = popcnt(pwdata[NP-1:0]) > 5'(MAX_MEMBERS); // R1
    assign isPortFlap  = paddr[7:6] == lag_pkg::OFS_PFLAP_TOP;

    // read data and error prepared in the setup cycle
    always_comb begin
        next_prdata  = '0;
        next_pslverr = 1'b0;
        if (isPortFlap) begin
            next_prdata[FW-1:0] = portFlap[paddr[5:2]];
            next_pslverr        = pwrite;
        end else begin
            case (paddr)
                lag_pkg::OFS_CTRL: begin
                    next_prdata[7:0] = {hashSel, staticMode, localPref,
                                        linkTrap, stpMode, adminEn};
                end
                lag_pkg::OFS_MEMBERS: begin
                    next_prdata[NP-1:0] = memberMask;
                    next_pslverr        = pwrite && overLimit; // R1
                end
                lag_pkg::OFS_PORT_ADMIN: next_prdata[NP-1:0] = portAdmin;
                lag_pkg::OFS_LOCAL_UNIT: next_prdata[NP-1:0] = localMask;
                lag_pkg::OFS_STATUS: begin
                    next_prdata[NP-1:0]             = activeMask;
                    next_prdata[lag_pkg::STAT_LINK+:2] = linkState;
                    next_prdata[lag_pkg::STAT_REJECT]  = rejected;
                    next_pslverr                    = pwrite;
                end
                lag_pkg::OFS_GRP_FLAP: begin
                    next_prdata[FW-1:0] = grpFlap;
                    next_pslverr        = pwrite;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // apb answer: one wait-free access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adminEn    <= 1'b1;
            stpMode    <= 1'b0;
            linkTrap   <= 1'b0;
            localPref  <= 1'b0;
            staticMode <= 1'b0;
            hashSel    <= lag_pkg::HASH_RST;
        end else if (wrCtrl) begin
            adminEn    <= pwdata[lag_pkg::CTRL_ADMIN];
            stpMode    <= pwdata[lag_pkg::CTRL_STP];
            linkTrap   <= pwdata[lag_pkg::CTRL_TRAP];
            localPref  <= pwdata[lag_pkg::CTRL_LOCAL];
            staticMode <= pwdata[lag_pkg::CTRL_STATIC];
            hashSel    <= pwdata[lag_pkg::CTRL_HASH+:3];
        end
    end

    // membership; an oversized set is refused and flagged
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            memberMask <= '0;
            rejected   <= 1'b0;
        end else if (accessEnd && pwrite && paddr == lag_pkg::OFS_MEMBERS) begin
            rejected <= overLimit; // R1
            if (!overLimit) begin
                memberMask <= pwdata[NP-1:0];
            end
        end
    end

    // port admin and local unit masks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            portAdmin <= lag_pkg::ADMIN_RST;
            localMask <= '0;
        end else begin
            if (wrPortAdmin) begin
                portAdmin <= pwdata[NP-1:0];
            end
            if (wrEn && paddr == lag_pkg::OFS_LOCAL_UNIT) begin
                localMask <= pwdata[NP-1:0];
            end
        end
    end

    // active set and group link state
    assign next_active = memberMask & portOperUp & portAdmin & portLink; // R2
    always_comb begin
        if (!adminEn || activeMask == '0) begin
            next_link = lag_pkg::LINK_DOWN; // R9
        end else if ((activeMask & portSfp) != '0) begin
            next_link = lag_pkg::LINK_UP_SFP; // R9
        end else begin
            next_link = lag_pkg::LINK_UP; // R9
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            activeMask <= '0;
            prevLink   <= '0;
            linkState  <= lag_pkg::LINK_DOWN;
            linkEvent  <= 1'b0;
        end else begin
            activeMask <= next_active;
            prevLink   <= portLink;
            linkState  <= next_link;
            linkEvent  <= linkTrap && next_link != linkState; // R10
        end
    end

    // port enables; disabled group or blocked tree stops all members
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txEnable  <= '0;
            rxEnable  <= '0;
            lacpBlock <= '0;
            stpGroup  <= 1'b0;
        end else begin
            txEnable  <= activeMask & {NP{adminEn && stpForward}}; // R15 R8
            rxEnable  <= activeMask & {NP{adminEn && stpForward}}; // R15 R8
            lacpBlock <= memberMask & {NP{staticMode}}; // R16
            stpGroup  <= stpMode; // R8
        end
    end

    // member flap counters; an event in the clear cycle still counts
    for (genvar i = 0; i < NP; i++) begin : g_pflap
        logic hit;
        assign hit = memberMask[i] && ((prevLink[i] && !portLink[i]) ||
                     (wrPortAdmin && portAdmin[i] && !pwdata[i])); // R11
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                portFlap[i] <= '0; // R17
            end else if (clearCmd) begin
                portFlap[i] <= hit ? FW'(1) : '0; // R14
            end else if (hit) begin
                portFlap[i] <= bump(portFlap[i]); // R17
            end
        end
    end

    // group flap counter
    logic grpHit;
    assign grpHit = (wrCtrl && adminEn && !pwdata[lag_pkg::CTRL_ADMIN]) // R12
                 || (activeMask != '0 && next_active == '0); // R13
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            grpFlap <= '0; // R17
        end else if (clearCmd) begin
            grpFlap <= grpHit ? FW'(1) : '0; // R14
        end else if (grpHit) begin
            grpFlap <= bump(grpFlap); // R17
        end
    end

    // frame queue ahead of the pick stage
    lag_frame_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (frameValid),
        .inReady  (frameReady),
        .inData   (frameDesc),
        .outValid (qValid),
        .outReady (qReady),
        .outData  (qBits)
    );
    assign qDesc   = lag_pkg::frame_desc_t'(qBits);
    assign qReady  = !egressValid || egressReady;
    assign selFire = qValid && qReady;

    // flow key from the selected fields
    always_comb begin
        case (hashSel) // R4
            lag_pkg::HASH_SRC_MAC: hashKey = {48'h0, qDesc.srcMac,
                qDesc.vlan, qDesc.etherType, qDesc.inPort};
            lag_pkg::HASH_DST_MAC: hashKey = {48'h0, qDesc.dstMac,
                qDesc.vlan, qDesc.etherType, qDesc.inPort};
            lag_pkg::HASH_SRC_IP:  hashKey = {80'h0, qDesc.srcIp,
                qDesc.srcL4};
            lag_pkg::HASH_DST_IP:  hashKey = {80'h0, qDesc.dstIp,
                qDesc.dstL4};
            lag_pkg::HASH_BOTH_IP: hashKey = {32'h0, qDesc.srcIp,
                qDesc.dstIp, qDesc.srcL4, qDesc.dstL4};
            default:               hashKey = {qDesc.srcMac, qDesc.dstMac,
                qDesc.vlan, qDesc.etherType, qDesc.inPort};
        endcase
    end

    // fold key to a byte, pick the nth candidate member
    always_comb begin
        hashVal = '0;
        for (int b = 0; b < 16; b++) begin
            hashVal = hashVal ^ hashKey[b*8+:8]; // R3
        end
        localAct = activeMask & localMask;
        if (localPref && qDesc.knownUnicast && localAct != '0) begin
            cand = localAct; // R5
        end else begin
            cand = activeMask; // R6 R7
        end
        candCnt = popcnt(cand);
        nth     = (candCnt == '0) ? '0 : hashVal % {3'h0, candCnt}; // R3
        seen    = '0;
        pick    = '0;
        for (int i = 0; i < NP; i++) begin
            if (cand[i]) begin
                if (seen == nth) begin
                    pick = 4'(i);
                end
                seen = seen + 1'b1;
            end
        end
        selDrop = !adminEn || !stpForward || candCnt == '0 // R15 R18
               || (qDesc.lacpFrame && staticMode); // R16
    end

    // egress register with back-pressure
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            egressValid <= 1'b0;
            egressDesc  <= '0;
        end else if (qReady) begin
            egressValid <= qValid;
            if (qValid) begin
                egressDesc.port <= pick;
                egressDesc.drop <= selDrop;
            end
        end
    end

    // checks
    a_member_limit: assert property (@(posedge clk_sys) disable iff (rst)
        popcnt(memberMask) <= 5'(MAX_MEMBERS)) // R1
        else $error("member count above limit");
    a_active_subset: assert property (@(posedge clk_sys) disable iff (rst)
        (activeMask & ~$past(memberMask)) == '0) // R2
        else $error("active port not a member");
    a_pick_active: assert property (@(posedge clk_sys) disable iff (rst)
        selFire |=> egressDesc.drop ||
        ($past(activeMask) & (16'h1 << egressDesc.port)) != '0) // R3
        else $error("egress port not active");
    a_local_pref: assert property (@(posedge clk_sys) disable iff (rst)
        selFire && localPref && qDesc.knownUnicast &&
        (activeMask & localMask) != '0 |=> egressDesc.drop ||
        ($past(localMask) & (16'h1 << egressDesc.port)) != '0) // R5
        else $error("known unicast left the local unit");
    a_admin_drop: assert property (@(posedge clk_sys) disable iff (rst)
        selFire && !adminEn |=> egressValid && egressDesc.drop) // R15
        else $error("disabled group forwarded");
    a_empty_drop: assert property (@(posedge clk_sys) disable iff (rst)
        selFire && activeMask == '0 |=> egressDesc.drop) // R18
        else $error("frame sent with no active member");
    a_lacp_static: assert property (@(posedge clk_sys) disable iff (rst)
        selFire && qDesc.lacpFrame && staticMode |=> egressDesc.drop) // R16
        else $error("lacp frame sent in static mode");
    a_link_down: assert property (@(posedge clk_sys) disable iff (rst)
        (activeMask == '0 || !adminEn) |=>
        linkState == lag_pkg::LINK_DOWN) // R9
        else $error("link not down without members");
    a_trap_event: assert property (@(posedge clk_sys) disable iff (rst)
        linkEvent == ($changed(linkState) && $past(linkTrap))) // R10
        else $error("link event mismatch");
    a_grp_last: assert property (@(posedge clk_sys) disable iff (rst) // R13
        $past(activeMask) != '0 && activeMask == '0 && !$past(clearCmd)
        && $past(grpFlap) != FLAP_MAX |-> grpFlap == $past(grpFlap) + 1'b1)
        else $error("group flap missed last member");
    a_clear_zero: assert property (@(posedge clk_sys) disable iff (rst)
        clearCmd |=> grpFlap <= FW'(1) && portFlap[0] <= FW'(1)) // R14
        else $error("clear left a count");
    a_flap_sat: assert property (@(posedge clk_sys) disable iff (rst)
        grpFlap == FLAP_MAX && !clearCmd |=> grpFlap == FLAP_MAX) // R17
        else $error("group flap wrapped");
endmodule : link_aggregation_group_control

// ===== core/lag_pkg.sv
// shared constants and types for the aggregation group controller
package lag_pkg;

    // sizes
    localparam int NUM_PORTS   = 16;
    localparam int PORT_IDX_W  = 4;
    localparam int MAX_MEMBERS = 8;
    localparam int FLAP_W      = 16;
    localparam int FIFO_DEPTH  = 4;
    localparam int KEY_W       = 128;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_MEMBERS    = 8'h04;
    localparam logic [7:0] OFS_PORT_ADMIN = 8'h08;
    localparam logic [7:0] OFS_LOCAL_UNIT = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_GRP_FLAP   = 8'h14;
    localparam logic [1:0] OFS_PFLAP_TOP  = 2'h1; // 0x40..0x7c, one per port

    // control register fields
    localparam int CTRL_ADMIN  = 0;
    localparam int CTRL_STP    = 1;
    localparam int CTRL_TRAP   = 2;
    localparam int CTRL_LOCAL  = 3;
    localparam int CTRL_STATIC = 4;
    localparam int CTRL_HASH   = 5;
    localparam int CTRL_CLEAR  = 8;

    // status register fields
    localparam int STAT_LINK   = 16;
    localparam int STAT_REJECT = 18;

    // reset values
    localparam logic [2:0]  HASH_RST  = 3'h2;
    localparam logic [15:0] ADMIN_RST = 16'hffff;

    typedef enum logic [1:0] {
        LINK_DOWN   = 2'h0,
        LINK_UP     = 2'h1,
        LINK_UP_SFP = 2'h2
    } link_state_t;

    typedef enum logic [2:0] {
        HASH_SRC_MAC  = 3'h0,
        HASH_DST_MAC  = 3'h1,
        HASH_BOTH_MAC = 3'h2,
        HASH_SRC_IP   = 3'h3,
        HASH_DST_IP   = 3'h4,
        HASH_BOTH_IP  = 3'h5
    } hash_sel_t;

    typedef struct packed {
        logic [47:0]           srcMac;
        logic [47:0]           dstMac;
        logic [11:0]           vlan;
        logic [15:0]           etherType;
        logic [PORT_IDX_W-1:0] inPort;
        logic [31:0]           srcIp;
        logic [31:0]           dstIp;
        logic [15:0]           srcL4;
        logic [15:0]           dstL4;
        logic                  knownUnicast;
        logic                  lacpFrame;
    } frame_desc_t;

    typedef struct packed {
        logic [PORT_IDX_W-1:0] port;
        logic                  drop;
    } egress_t;

endpackage : lag_pkg

// ===== testbench/link_partner.sv
// link partner model: port link levels and egress draining
`timescale 1ns/10ps
module link_partner (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // bench control
    input  wire logic        stall,
    input  wire logic [15:0] linkReq,
    // toward the block
    input  wire logic        egressValid,
    output logic             egressReady,
    output logic [15:0]      portLink
);
    // links follow the bench; ready paces every other cycle or stalls
    always_ff @(posedge clk_sys) begin
        portLink    <= linkReq;
        egressReady <= !rst && !stall && !(egressValid && egressReady);
    end
endmodule : link_partner

// ===== testbench/testbench.sv
// self-checking bench for the aggregation group controller
`timescale 1ns/10ps
module testbench;
    logic                 clk_sys, rst, psel, penable, pwrite, err, lp;
    logic                 frameValid, frameReady, egressValid, egressReady;
    logic                 stpForward, stall, pready, pslverr, adm, stc;
    logic                 stpGroup, linkEvent;
    logic [7:0]           paddr, seed;
    logic [31:0]          pwdata, prdata, r;
    logic [15:0]          portLink, portOperUp, portSfp, linkReq, actv, loc;
    logic [15:0]          txEnable, rxEnable, lacpBlock;
    logic [16:0]          expQ[$];
    lag_pkg::frame_desc_t frameDesc;
    lag_pkg::egress_t     egressDesc;
    lag_pkg::link_state_t linkState;
    int                   num_errors, n_checks, nEv, i;

    link_aggregation_group_control u_link_aggregation_group_control (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .portLink(portLink),
        .portOperUp(portOperUp), .portSfp(portSfp), .stpForward(stpForward),
        .frameValid(frameValid), .frameReady(frameReady),
        .frameDesc(frameDesc), .egressValid(egressValid),
        .egressReady(egressReady), .egressDesc(egressDesc),
        .txEnable(txEnable), .rxEnable(rxEnable), .lacpBlock(lacpBlock),
        .stpGroup(stpGroup), .linkState(linkState), .linkEvent(linkEvent));
    link_partner u_link_partner (
        .clk_sys(clk_sys), .rst(rst), .stall(stall), .linkReq(linkReq),
        .egressValid(egressValid), .egressReady(egressReady),
        .portLink(portLink));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task check_val(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t value %h expected %h", $time, g, e);
        end
    endtask : check_val
    task check_egr(input lag_pkg::egress_t g, input logic [16:0] e);
        n_checks++;
        if (g.drop !== e[16] || (!e[16] && e[g.port] !== 1'b1)) begin
            num_errors++;
            $display("ERROR %0t egress %h allowed %h", $time, g, e);
        end
    endtask : check_egr
    // apb master: setup, access until pready, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check_val(r, e);
    endtask : rd
    task setc(input logic [31:0] v);
        apb(1'b1, lag_pkg::OFS_CTRL, v);
        {stc, lp, adm} = {v[4:3], v[0]};
    endtask : setc
    task settle(input string s);
        repeat (16) @(posedge clk_sys);
        $display("test %s done", s);
    endtask : settle
    // one frame; note the expected drop flag and allowed member mask
    task send(input logic k, input logic l);
        logic [15:0] m;
        m = (lp && k && (actv & loc) != 16'h0) ? actv & loc : actv;
        seed = lfsr(seed);
        frameDesc <= {{28{seed}}, k, l};
        frameValid <= 1'b1;
        do @(posedge clk_sys); while (frameReady !== 1'b1);
        expQ.push_back({!adm || !stpForward || m == 16'h0 || (l && stc), m});
        frameValid <= 1'b0;
        @(posedge clk_sys);
    endtask : send
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // watchdog
    initial begin
        #200us;
        num_errors++;
        give_verdict();
    end
    // egress monitor and link event count
    always @(posedge clk_sys) begin
        if (linkEvent === 1'b1) nEv++;
        if (egressValid === 1'b1 && egressReady === 1'b1)
            check_egr(egressDesc, expQ.pop_front());
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, frameValid, stall} = '0;
        {linkReq, portSfp, actv, loc, frameDesc} = '0;
        {rst, stpForward, adm, lp, stc} = 5'h18;
        portOperUp = 16'hffff;
        seed = 8'h0a;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(lag_pkg::OFS_CTRL, 32'h41);
        rd(lag_pkg::OFS_PORT_ADMIN, 32'hffff);
        apb(1'b1, 8'h20, 32'h0);
        check_val(32'(err), 32'h1);
        apb(1'b1, lag_pkg::OFS_MEMBERS, 32'h1ff);
        check_val(32'(err), 32'h1);
        rd(lag_pkg::OFS_MEMBERS, 32'h0);
        apb(1'b1, lag_pkg::OFS_MEMBERS, 32'hff);
        linkReq <= 16'hff;
        setc(32'h45);
        settle("members");
        rd(lag_pkg::OFS_STATUS, 32'h100ff);
        portSfp <= 16'hffff;
        settle("optical");
        rd(lag_pkg::OFS_STATUS, 32'h200ff);
        portSfp <= 16'h0;
        apb(1'b1, lag_pkg::OFS_PORT_ADMIN, 32'hfffe);
        actv = 16'hfe;
        settle("port admin");
        rd(lag_pkg::OFS_STATUS, 32'h100fe);
        rd(8'h40, 32'h1);
        for (int h = 0; h < 6; h++) begin
            setc((32'(h) << 5) | 32'h05);
            send(1'b1, 1'b0);
            send(1'b0, 1'b0);
        end
        apb(1'b1, lag_pkg::OFS_LOCAL_UNIT, 32'h6);
        loc = 16'h6;
        setc(32'h4d);
        send(1'b1, 1'b0);
        send(1'b0, 1'b0);
        apb(1'b1, lag_pkg::OFS_LOCAL_UNIT, 32'h1);
        loc = 16'h1;
        send(1'b1, 1'b0);
        stall <= 1'b1;
        fork
            repeat (8) send(1'b1, 1'b0);
        join_none
        repeat (30) @(posedge clk_sys);
        check_val(32'(frameReady), 32'h0);
        stall <= 1'b0;
        wait fork;
        settle("fifo");
        check_val(32'(expQ.size()), 32'h0);
        setc(32'h57);
        settle("static stp");
        check_val(32'(lacpBlock), 32'hff);
        check_val(32'(stpGroup), 32'h1);
        check_val(32'(txEnable), 32'hfe);
        send(1'b1, 1'b1);
        stpForward <= 1'b0;
        send(1'b1, 1'b0);
        stpForward <= 1'b1;
        i = nEv;
        linkReq <= 16'h0;
        actv = 16'h0;
        settle("link loss");
        rd(lag_pkg::OFS_GRP_FLAP, 32'h1);
        check_val(32'(nEv - i), 32'h1);
        send(1'b1, 1'b0);
        linkReq <= 16'hff;
        actv = 16'hfe;
        settle("link back");
        setc(32'h44);
        settle("group shutdown");
        rd(lag_pkg::OFS_GRP_FLAP, 32'h2);
        rd(8'h44, 32'h1);
        check_val(32'(rxEnable), 32'h0);
        send(1'b1, 1'b0);
        setc(32'h144);
        rd(lag_pkg::OFS_GRP_FLAP, 32'h0);
        rd(8'h40, 32'h0);
        settle("clear");
        give_verdict();
    end
endmodule : testbench
